// ===== logic/pab_backend.sv
// Behaviour
// - two non-overlapping phases from master sampling clock
// - eight two-bit stages plus final two-bit flash
// - each stage clock inverted from previous stage
// - delay line aligns codes into eighteen-bit word
// - correction merges aligned word into ten bits
// - word appears seventh sampling cycle after sample
// - one new word every sampling cycle thereafter
// - two output register stages on sampling clock
// - format select chooses encoding; held static outside
// - high select inverts msb for two's complement
// - high output enable floats data; low drives
`timescale 1ns/1ps
`include "pab_params.svh"
module pab_backend (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic SMP_CLK,
  input wire pab_pkg::pab_codes_t CODES,
  input wire logic OUTPUT_FORMAT_SELECT,
  input wire logic OUT_EN_N,
  output logic PHI1,
  output logic PHI2,
  output logic [8:0] STAGE_CLK,
  output pab_pkg::pab_word_t DATA_OUT,
  output logic [9:0] DATA_OE
);
  typedef struct packed {
    logic smp_prev;
    logic phi1;
    logic phi2;
    logic [8:0] stage_clk;
    pab_pkg::pab_codes_t align;
    pab_pkg::pab_word_t buf_a;
    pab_pkg::pab_word_t buf_b;
    logic oe;
  } pab_state_t;

  pab_state_t s_r;
  pab_state_t s_nxt;
  logic rise;
  logic fall;
  pab_pkg::pab_codes_t delayed;
  pab_pkg::pab_word_t corrected;

  // edges of the master sampling clock; the sample is taken on the rise
  assign rise = SMP_CLK & ~s_r.smp_prev;
  assign fall = ~SMP_CLK & s_r.smp_prev;

  // stage m is valid m+1 half-cycles after the sample; odd half-cycles
  // end on a fall, even ones on a rise, and the tap count lines every
  // code up with the flash code at the rise after it
  genvar m;
  generate
    for (m = 0; m < `PAB_NSTAGES; m++) begin : g_stage
      pab_delay #(
        .DEPTH((`PAB_ALIGN_H - (m + 1)) / 2)
      ) u_dl (
        .clk(SYS_CLK),
        .reset(RESET),
        .cap((m % 2 == 0) ? fall : rise),
        .shift(rise),
        .din(CODES.stage[m]),
        .dout(delayed.stage[m])
      );
    end
  endgenerate

  // the flash stage is last in line and needs no extra taps
  pab_delay #(
    .DEPTH(0)
  ) u_flash (
    .clk(SYS_CLK),
    .reset(RESET),
    .cap(fall),
    .shift(rise),
    .din(CODES.flash),
    .dout(delayed.flash)
  );

  // overlapping two-bit codes: each stage weighs twice the next,
  // the redundant bit absorbs comparator error; clamp at full scale
  always_comb begin
    logic [`PAB_SUM_W-1:0] sum;
    sum = {10'h000, s_r.align.flash};
    for (int k = 0; k < `PAB_NSTAGES; k++) begin
      sum = sum + (`PAB_SUM_W'(s_r.align.stage[k]) << (8 - k));
    end
    if (sum > `PAB_DATA_MAX) begin
      corrected = 10'h3ff;
    end else begin
      corrected = sum[`PAB_DATA_W-1:0];
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.smp_prev = SMP_CLK;
    // both phases low for one cycle around each edge
    s_nxt.phi1 = ~SMP_CLK & ~s_r.smp_prev;
    s_nxt.phi2 = SMP_CLK & s_r.smp_prev;
    case ({s_nxt.phi1, s_nxt.phi2})
      2'b10: s_nxt.stage_clk = `PAB_STG_PH1;
      2'b01: s_nxt.stage_clk = `PAB_STG_PH2;
      default: s_nxt.stage_clk = 9'h000;
    endcase
    if (rise) begin
      s_nxt.align = delayed;
      s_nxt.buf_a = corrected;
      s_nxt.buf_a[`PAB_MSB] = corrected[`PAB_MSB]
        ^ OUTPUT_FORMAT_SELECT;
      s_nxt.buf_b = s_r.buf_a;
    end
    s_nxt.oe = ~OUT_EN_N;
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PHI1 = s_r.phi1;
  assign PHI2 = s_r.phi2;
  assign STAGE_CLK = s_r.stage_clk;
  assign DATA_OUT = s_r.buf_b;
  assign DATA_OE = {10{s_r.oe}};

  // checking logic
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  pab_pkg::pab_code_t fall_flash_r;
  pab_pkg::pab_word_t hist_r [0:1];
  pab_pkg::pab_code_t [4:0] f0_r;
  pab_pkg::pab_code_t r7_r;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      fall_flash_r <= 2'h0;
      hist_r[0] <= 10'h000;
      hist_r[1] <= 10'h000;
      f0_r <= '0;
      r7_r <= 2'h0;
    end else begin
      if (fall) begin
        fall_flash_r <= CODES.flash;
        f0_r <= {f0_r[3:0], CODES.stage[0]};
      end
      if (rise) begin
        r7_r <= CODES.stage[7];
        hist_r[0] <= corrected;
        hist_r[1] <= hist_r[0];
      end
    end
  end

  sequence rise_s;
    rise;
  endsequence
  sequence quiet_s;
    !rise ##1 !rise;
  endsequence
  sequence fall_s;
    fall;
  endsequence
  sequence gap_s;
    !PHI1 && !PHI2;
  endsequence

  phase_overlap_a: assert property (
    !(PHI1 && PHI2) && !(PHI1 && $past(PHI2)) && !(PHI2 && $past(PHI1)))
    else $error("sampling phases overlap");
  stage_alternate_a: assert property (
    (PHI1 || PHI2) |-> (STAGE_CLK[0] == PHI1)
      && (STAGE_CLK[8:1] == ~STAGE_CLK[7:0]))
    else $error("neighbouring stage clocks not inverted");
  flash_align_a: assert property (
    rise_s |=> s_r.align.flash == $past(fall_flash_r))
    else $error("flash code not aligned with last fall");
  delay_line_a: assert property (
    rise_s |=> s_r.align == $past(delayed))
    else $error("aligned word not taken from delay line");
  correct_range_a: assert property (
    rise_s |=> (s_r.buf_a[8:0] == $past(corrected[8:0])))
    else $error("corrected word lost on output latch");
  latency_a: assert property (
    rise_s |=> DATA_OUT[8:0] == hist_r[1][8:0])
    else $error("output word not from two rises back");
  steady_a: assert property (
    rise_s |=> DATA_OUT == $past(s_r.buf_a))
    else $error("output did not advance on sampling rise");
  sync_out_a: assert property (
    quiet_s |=> $stable(DATA_OUT))
    else $error("output moved away from sampling rise");
  format_msb_a: assert property (
    rise_s |=> s_r.buf_a[9] == ($past(corrected[9])
      ^ $past(OUTPUT_FORMAT_SELECT)))
    else $error("format select not applied to msb");
  float_out_a: assert property (
    OUT_EN_N |=> DATA_OE == 10'h000)
    else $error("outputs driven while enable high");
  drive_out_a: assert property (
    !OUT_EN_N |=> DATA_OE == 10'h3ff)
    else $error("outputs floated while enable low");
  phase_follow_a: assert property (
    fall_s |=> gap_s ##1 PHI1)
    else $error("low phase did not follow sampling fall");
  phase_rise_a: assert property (
    rise_s |=> gap_s ##1 PHI2)
    else $error("high phase did not follow sampling rise");
  stage_first_a: assert property (
    rise_s |=> s_r.align.stage[0] == $past(f0_r[4]))
    else $error("first stage code not five falls old");
  stage_last_a: assert property (
    rise_s |=> s_r.align.stage[7] == $past(r7_r))
    else $error("last stage code not from previous rise");
endmodule

// ===== logic/pab_delay.sv
`timescale 1ns/1ps
// one delay-line tap chain: catch the code on its own phase edge,
// then walk it along DEPTH further taps on each sampling clock rise
module pab_delay #(
  parameter int DEPTH = 0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cap,
  input wire logic shift,
  input wire pab_pkg::pab_code_t din,
  output pab_pkg::pab_code_t dout
);
  typedef struct packed {
    pab_pkg::pab_code_t [DEPTH:0] tap;
  } pab_dl_t;

  pab_dl_t s_r;
  pab_dl_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (cap) begin
      s_nxt.tap[0] = din;
    end
    if (shift) begin
      for (int k = 1; k <= DEPTH; k++) begin
        s_nxt.tap[k] = s_r.tap[k-1];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.tap[DEPTH];
endmodule

// ===== logic/pab_params.svh
`ifndef PAB_PARAMS_SVH
`define PAB_PARAMS_SVH
// stage counts and code widths
`define PAB_NSTAGES 8
`define PAB_CODE_W 2
`define PAB_DATA_W 10
// sum of overlapping stage codes before clamping
`define PAB_SUM_W 12
`define PAB_DATA_MAX 12'h3ff
// bit flipped by the two's complement format
`define PAB_MSB 9
// half-cycle after the sample in which the last stage code is valid
`define PAB_ALIGN_H 9
// sampling-clock cycles from sample to output word
`define PAB_LATENCY 7
// stage clock patterns: even stages on the first phase
`define PAB_STG_PH1 9'h155
`define PAB_STG_PH2 9'h0aa
`endif

// ===== logic/pab_pkg.sv
package pab_pkg;
  typedef logic [1:0] pab_code_t;
  typedef logic [9:0] pab_word_t;
  // codes of the eight subconverters and the final flash stage
  typedef struct packed {
    pab_code_t [7:0] stage;
    pab_code_t flash;
  } pab_codes_t;
endpackage

// ===== tb/pab_sink.sv
`timescale 1ns/1ps
// capture side: takes a word at every sampling clock fall after the first twenty, while the pins are driven
module pab_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic smp_clk,
  input wire logic [9:0] data_oe,
  input wire pab_pkg::pab_word_t data_in,
  output logic valid,
  output pab_pkg::pab_word_t word
);
  logic smp_r;
  int falls_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      smp_r <= 1'b0;
      falls_r <= 0;
      valid <= 1'b0;
      word <= '0;
    end else begin
      smp_r <= smp_clk;
      valid <= 1'b0;
      if (smp_r && !smp_clk) begin
        falls_r <= falls_r + 1;
        // warm-up words are discarded; only driven pins are taken
        if (falls_r >= 20 && data_oe == 10'h3ff) begin
          valid <= 1'b1;
          word <= data_in;
        end
      end
    end
  end
endmodule

// ===== tb/test_pab_backend.sv
`timescale 1ns/1ps
module test_pab_backend;
  logic SYS_CLK = 0;
  logic RESET = 1;
  logic SMP_CLK = 0;
  pab_pkg::pab_codes_t CODES = '0;
  logic OUTPUT_FORMAT_SELECT = 0;
  logic OUT_EN_N = 0;
  logic PHI1, PHI2, valid;
  logic [8:0] STAGE_CLK;
  logic [9:0] DATA_OE;
  pab_pkg::pab_word_t DATA_OUT, word;
  pab_pkg::pab_codes_t smp [64];
  pab_pkg::pab_word_t q [$];
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h7b37f9db;
  initial forever #5 SYS_CLK = ~SYS_CLK;
  pab_backend dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .SMP_CLK(SMP_CLK),
    .CODES(CODES), .OUTPUT_FORMAT_SELECT(OUTPUT_FORMAT_SELECT),
    .OUT_EN_N(OUT_EN_N), .PHI1(PHI1), .PHI2(PHI2), .STAGE_CLK(STAGE_CLK),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  pab_sink sink_u (.clk(SYS_CLK), .reset(RESET), .smp_clk(SMP_CLK),
    .data_oe(DATA_OE), .data_in(DATA_OUT), .valid(valid), .word(word));
  task check(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // weighted overlap sum of the aligned codes, clamped, then formatted
  function automatic pab_pkg::pab_word_t calc_word(pab_pkg::pab_codes_t c,
                                                   logic fs);
    int s;
    s = c.flash;
    for (int m = 0; m < 8; m++) s += int'(c.stage[m]) << (8 - m);
    if (s > 1023) s = 1023;
    return 10'(s) ^ {fs, 9'h000};
  endfunction
  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    if (valid === 1'b1 && q.size() > 0) begin
      check("DATA_OUT", q.pop_front(), word);
    end
  end
  // stage m of sample n is offered in half-cycle 2n+m+1, flash in 2n+9
  task run(input logic fs);
    RESET = 1;
    SMP_CLK = 0;
    OUTPUT_FORMAT_SELECT = fs;
    repeat (2) @(posedge SYS_CLK);
    #1 RESET = 0;
    for (int n = 0; n < 64; n++) smp[n] = 18'($random(seed));
    for (int n = 13; n < 40; n++) q.push_back(calc_word(smp[n], fs));
    for (int t = 0; t < 96; t++) begin
      SMP_CLK = ~t[0];
      for (int m = 0; m < 8; m++) begin
        CODES.stage[m] = smp[((t + 127 - m) >> 1) & 63].stage[m];
      end
      CODES.flash = smp[((t + 119) >> 1) & 63].flash;
      repeat (2) @(posedge SYS_CLK);
      #1;
      if (t == 10 || t == 11) begin
        check("PHI", t[0] ? 10'h002 : 10'h001, {8'h00, PHI1, PHI2});
        check("STAGE_CLK", t[0] ? 10'h155 : 10'h0aa,
              {1'b0, STAGE_CLK});
      end
      repeat (2) @(posedge SYS_CLK);
      #1;
    end
    check("missing words", 10'h000, 10'(q.size()));
  endtask
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_fail++;
    conclude();
  end
  initial begin
    run(1'b0);
    OUT_EN_N = 1;
    @(posedge SYS_CLK);
    #1;
    check("DATA_OE", 10'h000, DATA_OE);
    OUT_EN_N = 0;
    @(posedge SYS_CLK);
    #1;
    check("DATA_OE", 10'h3ff, DATA_OE);
    run(1'b1);
    conclude();
  end
endmodule
